// [sacr_cfg.svh]
`ifndef SACR_CFG_SVH
`define SACR_CFG_SVH

// Register addresses.
`define SACR_ADDR_CONTROL_ONE     8'h01
`define SACR_ADDR_CONTROL_TWO     8'h02
`define SACR_ADDR_ADC_STEP_SIZE   8'h03
`define SACR_ADDR_BLACK_LEVEL     8'h04
`define SACR_ADDR_CONTROL_THREE   8'h05
`define SACR_ADDR_KNEE_ONE        8'h06
`define SACR_ADDR_KNEE_TWO        8'h07
`define SACR_ADDR_KNEE_THREE      8'h08
`define SACR_ADDR_RANGE_LIMIT     8'h09
`define SACR_ADDR_MONITOR_SELECT  8'h0A
`define SACR_ADDR_READBACK_PTR    8'h0F

// Reset values.
`define SACR_RST_CONTROL_ONE      8'hA8
`define SACR_RST_CONTROL_TWO      8'h12
`define SACR_RST_ADC_STEP_SIZE    8'h1D
`define SACR_RST_BLACK_LEVEL      8'hC8
`define SACR_RST_CONTROL_THREE    8'h12
`define SACR_RST_KNEE_ONE         8'h01
`define SACR_RST_KNEE_TWO         8'h06
`define SACR_RST_KNEE_THREE       8'h6D
`define SACR_RST_RANGE_LIMIT      8'h7F
`define SACR_RST_MONITOR_SELECT   8'h00
`define SACR_RST_READBACK_PTR     8'h00

// Field positions and scaling.
`define SACR_UPDATE_REQ_BIT       0
`define SACR_SCALE_ZEROS          5'h00
`define SACR_MONITOR_GND_CODE     4'h0
`define SACR_FRAME_BITS           16

`endif

// [sacr_pkg.sv]
package sacr_pkg;

   typedef enum logic [0:0] {
      SACR_CONV_IDLE,
      SACR_CONV_RUN
   } sacr_conv_e;

   typedef struct packed {
      logic [7:0] control_one;
      logic [7:0] control_two;
      logic [7:0] adc_step_size;
      logic [7:0] black_level_offset;
      logic [7:0] control_three;
      logic [7:0] knee_point_one;
      logic [7:0] knee_point_two;
      logic [7:0] knee_point_three;
      logic [7:0] adc_range_limit;
      logic [7:0] monitor_select;
      logic [7:0] readback_pointer;
   } sacr_map_s;

   typedef logic [12:0] sacr_code_t;

endpackage

// [sacr_link_if.sv]
`timescale 1ns/10ps
interface sacr_link_if;
   logic        frame_done;
   logic [15:0] frame_word;
   logic [7:0]  read_data;

   modport link
   (
      output frame_done,
      output frame_word,
      input  read_data
   );

   modport core
   (
      input  frame_done,
      input  frame_word,
      output read_data
   );
endinterface

// [sacr_sync.sv]
`timescale 1ns/10ps
module sacr_sync
   import sacr_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule

// [sacr_spi_link.sv]
`timescale 1ns/10ps
`include "sacr_cfg.svh"
module sacr_spi_link
   import sacr_pkg::*;
(
   // Serial pins; the serial clock is this module's clock.
   input  wire logic spi_sclk_i,
   input  wire logic spi_cs_n_i,
   input  wire logic spi_mosi_i,
   output logic      spi_miso_o,
   output logic      spi_miso_oe_o,
   // Towards the register core.
   sacr_link_if.link link
);
   typedef struct packed {
      logic [4:0]  bit_cnt;
      logic [15:0] shift;
   } sacr_spi_s;

   sacr_spi_s r;
   sacr_spi_s n;

   // Extra bits past a full frame are ignored; the count saturates.
   always_comb
   begin
      n = r;
      if (r.bit_cnt != 5'(`SACR_FRAME_BITS))
      begin
         n.shift   = {r.shift[14:0], spi_mosi_i};
         n.bit_cnt = r.bit_cnt + 5'h01;
      end
   end

   // Chip select high clears the frame, since the serial clock stops between frames.
   always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i)
   begin
      if (spi_cs_n_i)
         r <= '0;
      else
         r <= n;
   end

   assign link.frame_done = (r.bit_cnt == 5'(`SACR_FRAME_BITS));
   assign link.frame_word = r.shift;
   // Read-back byte goes out MSB first during the address phase.
   assign spi_miso_o      = (r.bit_cnt < 5'h08) ? link.read_data[3'h7 - r.bit_cnt[2:0]] : 1'b0;
   assign spi_miso_oe_o   = ~spi_cs_n_i;
endmodule

// [sacr_config_regs.sv]
`timescale 1ns/10ps
`include "sacr_cfg.svh"
module sacr_config_regs
   import sacr_pkg::*;
(
   // Master clock and reset.
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // Serial configuration pins.
   input  wire logic        spi_sclk_i,
   input  wire logic        spi_cs_n_i,
   input  wire logic        spi_mosi_i,
   output logic             spi_miso_o,
   output logic             spi_miso_oe_o,
   // Conversion start pin, end-of-conversion output and update-pending flag.
   input  wire logic        sample_i,
   output logic             end_adc_o,
   output logic             update_pending_o,
   // Applied configuration.
   output logic [7:0]       control_one_o,
   output logic [7:0]       control_two_o,
   output logic [7:0]       control_three_o,
   output logic [7:0]       adc_step_size_o,
   output logic [7:0]       black_level_offset_o,
   output sacr_code_t       knee_code_one_o,
   output sacr_code_t       knee_code_two_o,
   output sacr_code_t       knee_code_three_o,
   output sacr_code_t       range_code_o,
   output logic [3:0]       monitor_channel_o,
   output logic [3:0]       monitor_high_sel_o,
   output logic             monitor_gnd_o
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Reset map and register access helpers.

   localparam sacr_map_s MAP_RESET = '{
      control_one:        `SACR_RST_CONTROL_ONE,
      control_two:        `SACR_RST_CONTROL_TWO,
      adc_step_size:      `SACR_RST_ADC_STEP_SIZE,
      black_level_offset: `SACR_RST_BLACK_LEVEL,
      control_three:      `SACR_RST_CONTROL_THREE,
      knee_point_one:     `SACR_RST_KNEE_ONE,
      knee_point_two:     `SACR_RST_KNEE_TWO,
      knee_point_three:   `SACR_RST_KNEE_THREE,
      adc_range_limit:    `SACR_RST_RANGE_LIMIT,
      monitor_select:     `SACR_RST_MONITOR_SELECT,
      readback_pointer:   `SACR_RST_READBACK_PTR
   };

   function automatic logic [7:0] map_read(input sacr_map_s m, input logic [7:0] addr);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         `SACR_ADDR_CONTROL_ONE:    v = m.control_one;
         `SACR_ADDR_CONTROL_TWO:    v = m.control_two;
         `SACR_ADDR_ADC_STEP_SIZE:  v = m.adc_step_size;
         `SACR_ADDR_BLACK_LEVEL:    v = m.black_level_offset;
         `SACR_ADDR_CONTROL_THREE:  v = m.control_three;
         `SACR_ADDR_KNEE_ONE:       v = m.knee_point_one;
         `SACR_ADDR_KNEE_TWO:       v = m.knee_point_two;
         `SACR_ADDR_KNEE_THREE:     v = m.knee_point_three;
         `SACR_ADDR_RANGE_LIMIT:    v = m.adc_range_limit;
         `SACR_ADDR_MONITOR_SELECT: v = m.monitor_select;
         `SACR_ADDR_READBACK_PTR:   v = m.readback_pointer;
         default:                   v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic sacr_map_s map_write(input sacr_map_s m, input logic [7:0] addr,
                                           input logic [7:0] data);
      sacr_map_s w;
      w = m;
      unique case (addr)
         `SACR_ADDR_CONTROL_ONE:    w.control_one        = data;
         `SACR_ADDR_CONTROL_TWO:    w.control_two        = data;
         `SACR_ADDR_ADC_STEP_SIZE:  w.adc_step_size      = data;
         `SACR_ADDR_BLACK_LEVEL:    w.black_level_offset = data;
         `SACR_ADDR_CONTROL_THREE:  w.control_three      = data;
         `SACR_ADDR_KNEE_ONE:       w.knee_point_one     = data;
         `SACR_ADDR_KNEE_TWO:       w.knee_point_two     = data;
         `SACR_ADDR_KNEE_THREE:     w.knee_point_three   = data;
         `SACR_ADDR_RANGE_LIMIT:    w.adc_range_limit    = data;
         `SACR_ADDR_MONITOR_SELECT: w.monitor_select     = data;
         `SACR_ADDR_READBACK_PTR:   w.readback_pointer   = data;
         default:                   w = m;
      endcase
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Module state.

   typedef struct packed {
      sacr_map_s  staged;
      sacr_map_s  active;
      sacr_conv_e conv;
      sacr_code_t conv_cnt;
      logic       end_adc;
      logic [7:0] read_data;
      logic       done_seen;
      logic       sample_seen;
   } sacr_state_s;

   sacr_state_s r;
   sacr_state_s n;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Serial link and synchronisers.

   sacr_link_if link_bus ();

   logic [1:0] sync_out;
   logic       frame_done_s;
   logic       sample_s;

   sacr_spi_link u_spi_link
   (
      .spi_sclk_i    (spi_sclk_i),
      .spi_cs_n_i    (spi_cs_n_i),
      .spi_mosi_i    (spi_mosi_i),
      .spi_miso_o    (spi_miso_o),
      .spi_miso_oe_o (spi_miso_oe_o),
      .link          (link_bus.link)
   );

   sacr_sync #(.WIDTH(2)) u_sync
   (
      .clk_i   (sys_clk_i),
      .reset_i (reset_i),
      .async_i ({link_bus.frame_done, sample_i}),
      .sync_o  (sync_out)
   );

   assign frame_done_s = sync_out[1];
   assign sample_s     = sync_out[0];

   assign link_bus.read_data = r.read_data;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   logic       frame_rise;
   logic       sample_rise;
   logic       conv_finish;
   logic       apply_now;
   sacr_code_t conv_len;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   // The frame word is stable while the synchronised done level is high.
   assign wr_addr     = link_bus.frame_word[15:8];
   assign wr_data     = link_bus.frame_word[7:0];
   assign frame_rise  = frame_done_s & ~r.done_seen;
   assign sample_rise = sample_s & ~r.sample_seen;

   // A zero range still takes one cycle so the end flag always rises.
   assign conv_len    = (r.active.adc_range_limit == 8'h00) ? 13'h0001
                        : {r.active.adc_range_limit, `SACR_SCALE_ZEROS};
   assign conv_finish = (r.conv == SACR_CONV_RUN) && (r.conv_cnt == conv_len - 13'h0001);
   assign apply_now   = conv_finish && r.staged.control_one[`SACR_UPDATE_REQ_BIT];

   always_comb
   begin
      n             = r;
      n.done_seen   = frame_done_s;
      n.sample_seen = sample_s;

      unique case (r.conv)
         SACR_CONV_IDLE:
         begin
            if (sample_rise)
            begin
               n.conv     = SACR_CONV_RUN;
               n.conv_cnt = 13'h0000;
               n.end_adc  = 1'b0;
            end
         end
         SACR_CONV_RUN:
         begin
            if (conv_finish)
            begin
               n.conv    = SACR_CONV_IDLE;
               n.end_adc = 1'b1;
            end
            else
               n.conv_cnt = r.conv_cnt + 13'h0001;
         end
      endcase

      // Staged values move to the applied set on the end-of-conversion rise if the staged control-one update request bit is set.
      if (apply_now)
      begin
         n.active = r.staged;
         n.active.control_one[`SACR_UPDATE_REQ_BIT] = 1'b0;
         n.staged.control_one[`SACR_UPDATE_REQ_BIT] = 1'b0;
      end

      // A control-one write in the same cycle overrides the clear of the update request.
      if (frame_rise)
         n.staged = map_write(n.staged, wr_addr, wr_data);

      n.read_data = map_read(n.staged, n.staged.readback_pointer);

      if (reset_i)
      begin
         n.staged      = MAP_RESET;
         n.active      = MAP_RESET;
         n.conv        = SACR_CONV_IDLE;
         n.conv_cnt    = 13'h0000;
         n.end_adc     = 1'b0;
         n.read_data   = 8'h00;
         n.done_seen   = 1'b0;
         n.sample_seen = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      r <= n;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign end_adc_o            = r.end_adc;
   assign update_pending_o     = r.staged.control_one[`SACR_UPDATE_REQ_BIT];
   assign control_one_o        = r.active.control_one;
   assign control_two_o        = r.active.control_two;
   assign control_three_o      = r.active.control_three;
   assign adc_step_size_o      = r.active.adc_step_size;
   assign black_level_offset_o = r.active.black_level_offset;
   assign knee_code_one_o      = {r.active.knee_point_one, `SACR_SCALE_ZEROS};
   assign knee_code_two_o      = {r.active.knee_point_two, `SACR_SCALE_ZEROS};
   assign knee_code_three_o    = {r.active.knee_point_three, `SACR_SCALE_ZEROS};
   assign range_code_o         = {r.active.adc_range_limit, `SACR_SCALE_ZEROS};
   assign monitor_channel_o    = r.active.monitor_select[3:0];
   assign monitor_high_sel_o   = r.active.monitor_select[7:4];
   assign monitor_gnd_o        = (r.active.monitor_select[3:0] == `SACR_MONITOR_GND_CODE);
endmodule

// [sacr_config_regs_properties.sv]
`timescale 1ns/10ps
module sacr_cfg_checker
   import sacr_pkg::*;
(
   // Clock and reset.
   input wire logic       sys_clk_i,
   input wire logic       reset_i,
   // Watched pins.
   input wire logic       sample_i,
   input wire logic       end_adc_o,
   input wire logic       update_pending_o,
   input wire logic [7:0] control_one_o,
   input wire logic [7:0] control_two_o,
   input wire logic [7:0] control_three_o,
   input wire logic [7:0] adc_step_size_o,
   input wire logic [7:0] black_level_offset_o,
   input wire sacr_code_t knee_code_one_o,
   input wire sacr_code_t knee_code_two_o,
   input wire sacr_code_t knee_code_three_o,
   input wire sacr_code_t range_code_o,
   input wire logic [3:0] monitor_channel_o,
   input wire logic       monitor_gnd_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [12:0] low_cnt;
   logic        seen_hi;
   // Counts sampled low cycles of the current conversion.
   always_ff @(posedge sys_clk_i)
   begin
      low_cnt <= (reset_i || end_adc_o) ? 13'h0000 : low_cnt + 13'h0001;
      seen_hi <= reset_i ? 1'b0 : (seen_hi | end_adc_o);
   end
   property p_knee_scale;
      {knee_code_one_o[4:0], knee_code_two_o[4:0], knee_code_three_o[4:0]} == 15'h0000;
   endproperty
   a_knee_scale: assert property (p_knee_scale) else $error("knee code low bits set");
   property p_range_scale;
      range_code_o[4:0] == 5'h00;
   endproperty
   a_range_scale: assert property (p_range_scale) else $error("range low bits set");
   property p_conv_length;
      $rose(end_adc_o) && seen_hi |->
         low_cnt == (($past(range_code_o) == 13'h0000) ? 13'h0001 : $past(range_code_o));
   endproperty
   a_conv_length: assert property (p_conv_length) else $error("bad conversion length");
   property p_start_falls;
      $rose(sample_i) && end_adc_o |-> ##[1:6] !end_adc_o;
   endproperty
   a_start_falls: assert property (p_start_falls) else $error("start not taken");
   property p_monitor_gnd;
      monitor_gnd_o == (monitor_channel_o == 4'h0);
   endproperty
   a_monitor_gnd: assert property (p_monitor_gnd) else $error("ground flag wrong");
   property p_apply_on_end;
      $changed({control_two_o, knee_code_one_o, range_code_o, black_level_offset_o})
         |-> $rose(end_adc_o);
   endproperty
   a_apply_on_end: assert property (p_apply_on_end) else $error("applied early");
   property p_hold;
      $rose(end_adc_o) && !$past(update_pending_o) |->
         $stable(control_three_o) && $stable(knee_code_three_o);
   endproperty
   a_hold: assert property (p_hold) else $error("applied without request");
   property p_pending_clear;
      $rose(end_adc_o) && $past(update_pending_o) |-> !update_pending_o;
   endproperty
   a_pending_clear: assert property (p_pending_clear) else $error("request kept");
   property p_reset_map;
      $fell(reset_i) |->
         {control_one_o, control_two_o, adc_step_size_o, black_level_offset_o,
          control_three_o} == 40'hA8121DC812 && monitor_gnd_o && !end_adc_o &&
         {knee_code_one_o, knee_code_two_o, knee_code_three_o, range_code_o} ==
         {13'h0020, 13'h00C0, 13'h0DA0, 13'h0FE0};
   endproperty
   a_reset_map: assert property (p_reset_map) else $error("bad reset map");
   c_apply: cover property ($rose(end_adc_o) && $past(update_pending_o));
   c_start: cover property ($rose(sample_i) && end_adc_o);
   c_monitor: cover property (!monitor_gnd_o);
endmodule
bind sacr_config_regs sacr_cfg_checker sacr_cfg_checker_i
(
   .sys_clk_i, .reset_i, .sample_i, .end_adc_o, .update_pending_o, .control_one_o,
   .control_two_o, .control_three_o, .adc_step_size_o, .black_level_offset_o,
   .knee_code_one_o, .knee_code_two_o, .knee_code_three_o, .range_code_o,
   .monitor_channel_o, .monitor_gnd_o
);

// [sacr_host_model.sv]
`timescale 1ns/10ps
module sacr_host_model
(
   // Serial pins towards the device.
   output logic      spi_sclk_o,
   output logic      spi_cs_n_o,
   output logic      spi_mosi_o,
   input  wire logic spi_miso_i,
   input  wire logic spi_miso_oe_i
);
   initial
   begin
      spi_sclk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b1;
   end
   // The serial clock stands still between frames.
   task automatic frame(input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rd);
      logic [15:0] word;
      word = {addr, data};
      #7;
      spi_cs_n_o = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_mosi_o = word[i];
         #16;
         if (i > 7)
            rd[i-8] = spi_miso_oe_i ? spi_miso_i : 1'bx;
         spi_sclk_o = 1'b1;
         #16;
         spi_sclk_o = 1'b0;
      end
      spi_mosi_o = ~word[0];
      #150;
      spi_cs_n_o = 1'b1;
      #150;
   endtask
endmodule

// [tb_sacr_config_regs.sv]
`timescale 1ns/10ps
module tb_sacr_config_regs
   import sacr_pkg::*;
;
   logic       sys_clk_i = 1'b0;
   logic       reset_i   = 1'b1;
   logic       sample_i  = 1'b0;
   wire        sclk, cs_n, mosi, miso, miso_oe;
   logic       end_adc, pend, mgnd;
   logic [7:0] c1, c2, c3, step, black;
   logic [3:0] mch, mhi;
   sacr_code_t k1, k2, k3, rng;
   int         miscompares = 0;
   int         compares    = 0;
   logic [7:0] rb_addr [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                8'h09, 8'h0A, 8'h0F};
   logic [7:0] rb_val  [11] = '{8'hA8, 8'h12, 8'h1D, 8'hC8, 8'h12, 8'h01, 8'h06, 8'h6D,
                                8'h7F, 8'h00, 8'h0F};
   logic [7:0] wv      [9]  = '{8'h33, 8'h44, 8'h55, 8'h21, 8'h0A, 8'h3C, 8'hF1, 8'h01,
                                8'h9B};
   always #12.5 sys_clk_i = ~sys_clk_i;
   sacr_config_regs sacr_config_regs_i
   (
      .sys_clk_i, .reset_i, .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
      .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .sample_i, .end_adc_o(end_adc),
      .update_pending_o(pend), .control_one_o(c1), .control_two_o(c2),
      .control_three_o(c3), .adc_step_size_o(step), .black_level_offset_o(black),
      .knee_code_one_o(k1), .knee_code_two_o(k2), .knee_code_three_o(k3),
      .range_code_o(rng), .monitor_channel_o(mch), .monitor_high_sel_o(mhi),
      .monitor_gnd_o(mgnd)
   );
   sacr_host_model sacr_host_model_i
   (
      .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .spi_miso_i(miso),
      .spi_miso_oe_i(miso_oe)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] nc;
      sacr_host_model_i.frame(a, d, nc);
   endtask
   // Points the read-back at an address, then shifts it out with an ignored write.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      wr(8'h0F, a);
      sacr_host_model_i.frame(8'h00, 8'h00, v);
      check(16'(v), 16'(exp));
   endtask
   // Runs one conversion; a negative length skips the length check.
   task automatic conv(input int len);
      int n;
      n = 0;
      @(negedge sys_clk_i);
      sample_i = 1'b1;
      for (int i = 0; i < 9000 && !(n > 0 && end_adc === 1'b1); i++)
      begin
         @(negedge sys_clk_i);
         if (i == 3)
            sample_i = 1'b0;
         if (end_adc === 1'b0)
            n++;
      end
      if (len >= 0)
         check(n[15:0], len[15:0]);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_map;
      check({c1, c2}, 16'hA812);
      check({c3, step}, 16'h121D);
      check({black, mch, mhi}, 16'hC800);
      check({k1, mgnd, pend, end_adc}, 16'h0104);
      check({k2, k3[2:0]}, 16'h0600);
      check(16'(k3), 16'h0DA0);
      check(16'(rng), 16'h0FE0);
      for (int i = 0; i < 11; i++)
         rd_chk(rb_addr[i], rb_val[i]);
      conv(-1);
   endtask
   task automatic t_unmapped;
      logic [7:0] bad [7] = '{8'h00, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'hFF};
      for (int i = 0; i < 7; i++)
      begin
         wr(bad[i], 8'h5A);
         rd_chk(bad[i], 8'h00);
      end
   endtask
   task automatic t_staged;
      for (int i = 0; i < 9; i++)
      begin
         wr(8'(i + 2), wv[i]);
         rd_chk(8'(i + 2), wv[i]);
      end
      conv(4064);
      check(16'(c2), 16'h0012);
      check(16'(k1), 16'h0020);
      wr(8'h01, 8'hA9);
      check(16'(pend), 16'h0001);
      conv(4064);
      check({c1, c2}, 16'hA833);
      check(16'(pend), 16'h0000);
      check({c3, step}, 16'h2144);
      check(16'(black), 16'h0055);
      check(16'(k1), 16'h0140);
      check(16'(k2), 16'h0780);
      check(16'(k3), 16'h1E20);
      check(16'(rng), 16'h0020);
      check(16'({mhi, mch, mgnd}), 16'h0136);
      conv(32);
   endtask
   task automatic t_monitor;
      logic [3:0] j;
      for (int i = 0; i < 16; i++)
      begin
         j = i[3:0];
         wr(8'h0A, {~j, j});
         wr(8'h01, 8'hA9);
         conv(32);
         check(16'({mhi, mch, mgnd}), 16'({~j, j, j == 4'h0}));
      end
   endtask
   task automatic t_resolution;
      logic [7:0] r [3] = '{8'h20, 8'h40, 8'h80};
      int         prev;
      prev = 1;
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h09, r[i]);
         wr(8'h01, 8'hA9);
         conv(prev * 32);
         check(16'(rng), 16'({r[i], 5'h00}));
         prev = r[i];
      end
      conv(4096);
   endtask
   task automatic t_reset_mid;
      @(negedge sys_clk_i);
      reset_i = 1'b1;
      repeat (5) @(negedge sys_clk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      check({c1, c2}, 16'hA812);
      check(16'({mhi, mch}), 16'h0000);
      check(16'(k2), 16'h00C0);
      check(16'(k3), 16'h0DA0);
      rd_chk(8'h09, 8'h7F);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(negedge sys_clk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      t_reset_map();
      t_unmapped();
      t_staged();
      t_monitor();
      t_resolution();
      t_reset_mid();
      test_done();
   end
   initial
   begin
      // About two and a half times the expected run of some 24,000 master clock cycles.
      #1_500_000;
      miscompares++;
      test_done();
   end
endmodule
